// file: core/mgac_gpio_cfg.sv
/*
 * Two configuration registers and the open-drain logic of three
 * multi-function pins, with alert routing.
 * Assumes the two-wire engine presents one-cycle read and write
 * strobes, and the pins are synchronous to i_mclk.
 */
// Notes on behaviour
// - pins only pull low; reads show pin level
// - lock bit blocks writes to both registers
// - bits 5:4 route alert to pin 1-3
// - routed alert overrides pin function setting
// - codes 000 and 110 release the pin
// - codes 001-100 pull low on zone exceed
// - code 101 pulls low on any zone
// - code 111 drives pin from data bit
// - first register: function 2:0, data bit 3
// - data bit reaches pin only in 111
// - second register: pin 3 in 3:0
// - second register: pin 2 data bit 7
// - both registers reset to 00
// - exceed means temperature above signed limit
`timescale 1ns/100ps
`include "mgac_params.svh"

module mgac_gpio_cfg (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rstn,
    input  wire mgac_pkg::mgac_req_s  i_req,
    input  wire logic                 i_lock,
    input  wire logic                 i_alert,
    input  wire mgac_pkg::mgac_zone_s i_zone,
    input  wire logic       [2:0]     i_pin,
    output logic            [2:0]     o_pin_out,
    output logic            [2:0]     o_pin_oe,
    output logic            [7:0]     o_rdata,
    output logic                      o_rhit
);
    import mgac_pkg::*;

    mgac_state_s st;
    mgac_state_s next_st;
    logic [3:0]  exceed;
    logic [2:0]  pout;

    mgac_zone_cmp u_cmp (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_zone   (i_zone),
        .o_exceed (exceed)
    );

    // ----------------------------------------------------------------
    // pin decode
    // ----------------------------------------------------------------
    // returns 1 when the pin is to be pulled low
    function automatic logic pull_low(input logic [2:0] fn, input logic dat,
                                      input logic [3:0] exc);
        logic r;
        r = 1'b0;
        case (fn)
            `MGAC_FN_IN0, `MGAC_FN_IN1: r = 1'b0;
            `MGAC_FN_ANY:              r = |exc;
            `MGAC_FN_IO:               r = ~dat;
            default:                   r = exc[2'(fn - 3'h1)];
        endcase
        return r;
    endfunction : pull_low

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (i_req.wr && !i_lock) begin
            if (i_req.addr == `MGAC_OFS_CFG1) begin
                next_st.route = i_req.wdata[`MGAC_CFG1_ROUTE_LSB +: 2];
                next_st.data1 = i_req.wdata[`MGAC_CFG1_DATA_BIT];
                next_st.func1 = i_req.wdata[`MGAC_CFG1_FUNC_LSB +: 3];
            end
            if (i_req.addr == `MGAC_OFS_CFG2) begin
                next_st.data2 = i_req.wdata[`MGAC_CFG2_DATA2_BIT];
                next_st.func2 = i_req.wdata[`MGAC_CFG2_FUNC2_LSB +: 3];
                next_st.data3 = i_req.wdata[`MGAC_CFG2_DATA3_BIT];
                next_st.func3 = i_req.wdata[`MGAC_CFG2_FUNC3_LSB +: 3];
            end
        end
        next_st.pull[0] = pull_low(st.func1, st.data1, exceed);
        next_st.pull[1] = pull_low(st.func2, st.data2, exceed);
        next_st.pull[2] = pull_low(st.func3, st.data3, exceed);
        // routed alert takes the pin whatever its function
        case (st.route)
            `MGAC_RT_PIN1: next_st.pull[0] = i_alert;
            `MGAC_RT_PIN2: next_st.pull[1] = i_alert;
            `MGAC_RT_PIN3: next_st.pull[2] = i_alert;
            default:       ;
        endcase
        // data bits read back the pin level, not the stored value
        if (i_req.rd) begin
            next_st.hit   = 1'b1;
            next_st.rdata = 8'h00;
            case (i_req.addr)
                `MGAC_OFS_CFG1: next_st.rdata = {2'h0, st.route, i_pin[0],
                                                 st.func1};
                `MGAC_OFS_CFG2: next_st.rdata = {i_pin[1], st.func2,
                                                 i_pin[2], st.func3};
                default:        next_st.hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st   <= '0;
            pout <= '0;
        end else begin
            st   <= next_st;
            pout <= '0;
        end
    end

    assign o_pin_out = pout;
    assign o_pin_oe  = st.pull;
    assign o_rdata   = st.rdata;
    assign o_rhit    = st.hit;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence s_rd1;
        i_req.rd && i_req.addr == `MGAC_OFS_CFG1;
    endsequence
    sequence s_rd2;
        i_req.rd && i_req.addr == `MGAC_OFS_CFG2;
    endsequence
    sequence s_wr2;
        !i_lock && i_req.wr && i_req.addr == `MGAC_OFS_CFG2;
    endsequence

    property p_lock;
        i_lock && i_req.wr |=> $stable({st.route, st.data1, st.func1, st.data2,
                                       st.func2, st.data3, st.func3});
    endproperty
    a_lock: assert property (p_lock) else $error("locked write changed a register");

    property p_write_read;
        !i_lock && i_req.wr && i_req.addr == `MGAC_OFS_CFG1 ##1 s_rd1
            |=> o_rdata[5:0] == {$past(i_req.wdata[5:4], 2), $past(i_pin[0]),
                                 $past(i_req.wdata[2:0], 2)} && o_rhit;
    endproperty
    a_write_read: assert property (p_write_read) else $error("first register readback wrong");

    property p_rsv;
        s_rd1 |=> o_rdata[7:6] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

    property p_pin2_read;
        s_rd2 |=> o_rdata[7] == $past(i_pin[1]) && o_rdata[3] == $past(i_pin[2]);
    endproperty
    a_pin2_read: assert property (p_pin2_read) else $error("pin level readback wrong");

    property p_input;
        (st.func1 == `MGAC_FN_IN0 || st.func1 == `MGAC_FN_IN1)
            && st.route != `MGAC_RT_PIN1 |=> !o_pin_oe[0];
    endproperty
    a_input: assert property (p_input) else $error("input pin pulled low");

    property p_zone;
        st.func3 == `MGAC_FN_ZONE4 && st.route != `MGAC_RT_PIN3
            |=> o_pin_oe[2] == $past(exceed[3]);
    endproperty
    a_zone: assert property (p_zone) else $error("zone status not on pin");

    property p_any;
        st.func2 == `MGAC_FN_ANY && st.route != `MGAC_RT_PIN2
            |=> o_pin_oe[1] == $past(|exceed);
    endproperty
    a_any: assert property (p_any) else $error("any-zone status not on pin");

    property p_io;
        st.func1 == `MGAC_FN_IO && st.route != `MGAC_RT_PIN1
            |=> o_pin_oe[0] == !$past(st.data1);
    endproperty
    a_io: assert property (p_io) else $error("io mode not following data bit");

    property p_route;
        st.route == `MGAC_RT_PIN2 |=> o_pin_oe[1] == $past(i_alert);
    endproperty
    a_route: assert property (p_route) else $error("routed alert not on pin");

    property p_drive;
        o_pin_out == 3'h0;
    endproperty
    a_drive: assert property (p_drive) else $error("pin driven high");

    property p_wr2_read;
        s_wr2 ##1 s_rd2
            |=> o_rdata[6:4] == $past(i_req.wdata[6:4], 2)
                && o_rdata[2:0] == $past(i_req.wdata[2:0], 2);
    endproperty
    a_wr2_read: assert property (p_wr2_read) else $error("second register readback wrong");

    property p_route1;
        st.route == `MGAC_RT_PIN1 |=> o_pin_oe[0] == $past(i_alert);
    endproperty
    a_route1: assert property (p_route1) else $error("alert not on pin 1");

    property p_route3;
        st.route == `MGAC_RT_PIN3 |=> o_pin_oe[2] == $past(i_alert);
    endproperty
    a_route3: assert property (p_route3) else $error("alert not on pin 3");

    property p_zone1;
        st.func1 >= `MGAC_FN_ZONE1 && st.func1 <= `MGAC_FN_ZONE4
            && st.route != `MGAC_RT_PIN1
            |=> o_pin_oe[0] == $past(exceed[2'(st.func1 - 3'h1)]);
    endproperty
    a_zone1: assert property (p_zone1) else $error("zone status not on pin 1");

    property p_io2;
        st.func2 == `MGAC_FN_IO && st.route != `MGAC_RT_PIN2
            |=> o_pin_oe[1] == !$past(st.data2);
    endproperty
    a_io2: assert property (p_io2) else $error("pin 2 not following data bit");

    property p_io3;
        st.func3 == `MGAC_FN_IO && st.route != `MGAC_RT_PIN3
            |=> o_pin_oe[2] == !$past(st.data3);
    endproperty
    a_io3: assert property (p_io3) else $error("pin 3 not following data bit");

endmodule : mgac_gpio_cfg

// file: core/mgac_params.svh
/*
 * Offsets, field positions, codes and reset values of the pin
 * configuration block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MGAC_PARAMS_SVH
`define MGAC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MGAC_OFS_CFG1        8'h19
`define MGAC_OFS_CFG2        8'h1A

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MGAC_RST_CFG1        8'h00
`define MGAC_RST_CFG2        8'h00
`define MGAC_RST_LIMIT       8'h5A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MGAC_CFG1_FUNC_LSB   0
`define MGAC_CFG1_DATA_BIT   3
`define MGAC_CFG1_ROUTE_LSB  4
`define MGAC_CFG2_FUNC3_LSB  0
`define MGAC_CFG2_DATA3_BIT  3
`define MGAC_CFG2_FUNC2_LSB  4
`define MGAC_CFG2_DATA2_BIT  7

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define MGAC_FN_IN0          3'h0
`define MGAC_FN_ZONE1        3'h1
`define MGAC_FN_ZONE4        3'h4
`define MGAC_FN_ANY          3'h5
`define MGAC_FN_IN1          3'h6
`define MGAC_FN_IO           3'h7

// ----------------------------------------------------------------
// alert routing codes
// ----------------------------------------------------------------
`define MGAC_RT_OFF          2'h0
`define MGAC_RT_PIN1         2'h1
`define MGAC_RT_PIN2         2'h2
`define MGAC_RT_PIN3         2'h3

`endif

// file: core/mgac_pkg.sv
/*
 * Types shared by the pin configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mgac_pkg;

    typedef logic [3:0][7:0] mgac_temp_t;

    // temperatures and fan-on limits of the four zones
    typedef struct packed {
        mgac_temp_t temp;
        mgac_temp_t limit;
    } mgac_zone_s;

    // register port from the two-wire engine
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } mgac_req_s;

    typedef struct packed {
        logic [1:0] route;
        logic       data1;
        logic [2:0] func1;
        logic       data2;
        logic [2:0] func2;
        logic       data3;
        logic [2:0] func3;
        logic [2:0] pull;
        logic [7:0] rdata;
        logic       hit;
    } mgac_state_s;

    typedef struct packed {
        logic [3:0] exceed;
    } mgac_cmp_s;

endpackage : mgac_pkg

// file: core/mgac_zone_cmp.sv
/*
 * Registered signed compare of each zone temperature against its
 * fan-on limit.
 * Assumes temperatures and limits are synchronous to i_mclk.
 */
`timescale 1ns/100ps
`include "mgac_params.svh"

module mgac_zone_cmp (
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    input  wire mgac_pkg::mgac_zone_s i_zone,
    output logic       [3:0]       o_exceed
);
    import mgac_pkg::*;

    mgac_cmp_s st;
    mgac_cmp_s next_st;

    // ----------------------------------------------------------------
    // compare
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        for (int z = 0; z < 4; z++) begin
            next_st.exceed[z] = $signed(i_zone.temp[z]) > $signed(i_zone.limit[z]);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_exceed = st.exceed;

endmodule : mgac_zone_cmp

// file: tb/mgac_board.sv
/*
 * Board model of the three open-drain pins: pull-ups plus an
 * outside agent that may hold any pin low.
 * Assumes an enable that is high while the device pulls the pin.
 */
`timescale 1ns/100ps

module mgac_board (
    input  wire logic [2:0] i_oe,
    input  wire logic [2:0] i_out,
    input  wire logic [2:0] i_ext_low,
    output logic      [2:0] o_level
);
    // pull-up wins unless either side pulls low
    assign o_level = ~((i_oe & ~i_out) | i_ext_low);
endmodule : mgac_board

// file: tb/tb_mgac_gpio_cfg.sv
/*
 * Self-checking bench of the pin configuration block.
 * Assumes the board model in mgac_board.sv and the shared package.
 */
`timescale 1ns/100ps
`include "mgac_params.svh"

module tb_mgac_gpio_cfg;
    import mgac_pkg::*;
    logic       i_mclk, i_rstn, i_lock, i_alert, rhit, r;
    mgac_req_s  req;
    mgac_zone_s zone;
    logic [2:0] pin, ext_low, pin_out, pin_oe;
    logic [7:0] rdata, c1, c2, d1, d2;
    logic [8:0] exp_q[$];
    int         mismatches, compares, cycles, seed;

    mgac_gpio_cfg dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .i_lock(i_lock),
        .i_alert(i_alert), .i_zone(zone), .i_pin(pin), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_rdata(rdata), .o_rhit(rhit));
    mgac_board board_u (.i_oe(pin_oe), .i_out(pin_out), .i_ext_low(ext_low), .o_level(pin));

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // expected pull-down enables from shadow registers and zone state
    function automatic logic [2:0] exp_oe(input logic [7:0] a, input logic [7:0] b,
                                          input logic al);
        logic [3:0] ex;
        logic [2:0] f [3];
        logic [2:0] d, o;
        for (int k = 0; k < 4; k++)
            ex[k] = $signed(zone.temp[k]) > $signed(zone.limit[k]);
        f[0] = a[2:0];
        f[1] = b[6:4];
        f[2] = b[2:0];
        d = {b[3], b[7], a[3]};
        for (int k = 0; k < 3; k++)
            case (f[k])
                3'h0, 3'h6: o[k] = 1'b0;
                3'h5: o[k] = |ex;
                3'h7: o[k] = ~d[k];
                default: o[k] = ex[f[k] - 3'h1];
            endcase
        if (a[5:4] != 2'h0)
            o[a[5:4] - 2'h1] = al;
        return o;
    endfunction : exp_oe

    // ----------------------------------------------------------------
    // register port driver
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge i_mclk) #1;
    endtask : wr

    task automatic rdx(input logic [7:0] a);
        case (a)
            `MGAC_OFS_CFG1: exp_q.push_back({1'b1, 2'b00, c1[5:4], pin[0], c1[2:0]});
            `MGAC_OFS_CFG2: exp_q.push_back({1'b1, pin[1], c2[6:4], pin[2], c2[2:0]});
            default: exp_q.push_back(9'h000);
        endcase
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge i_mclk) #1;
    endtask : rdx

    // read answers stand from the edge that takes the strobe
    always @(posedge i_mclk) begin
        r = req.rd;
        #2;
        if (r)
            chk({rhit, rdata}, exp_q.pop_front());
    end

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 94;
        i_rstn = 1'b0;
        i_lock = 1'b0;
        i_alert = 1'b0;
        req = '0;
        zone = '0;
        ext_low = 3'h0;
        {c1, c2} = '0;
        repeat (8) @(posedge i_mclk);
        #1 i_rstn = 1'b1;
        chk({6'h00, pin_oe}, 9'h000);
        rdx(`MGAC_OFS_CFG1);
        rdx(`MGAC_OFS_CFG2);
        for (int i = 0; i < 48; i++) begin
            zone = {$random(seed), $random(seed)};
            if (i % 4 == 0)
                zone.limit[i % 3] = zone.temp[i % 3];
            i_alert = $random(seed);
            ext_low = $random(seed);
            i_lock = (i >= 40);
            d1 = $random(seed);
            d2 = $random(seed);
            d1[5:0] = {i[4:3], d1[3], i[2:0]};
            d2[6:4] = i[2:0] + 3'h3;
            wr(`MGAC_OFS_CFG1, d1);
            wr(`MGAC_OFS_CFG2, d2);
            req = '0;
            if (!i_lock) begin
                c1 = d1;
                c2 = d2;
            end
            @(posedge i_mclk) #1;
            chk({6'h00, pin_oe}, {6'h00, exp_oe(c1, c2, i_alert)});
            chk({6'h00, pin_out}, 9'h000);
            rdx(`MGAC_OFS_CFG1);
            rdx(`MGAC_OFS_CFG2);
            rdx(8'h1B);
            req = '0;
            @(posedge i_mclk) #1;
        end
        // mid-run reset, then writes each followed at once by a read
        i_rstn = 1'b0;
        i_lock = 1'b0;
        {c1, c2} = '0;
        repeat (2) @(posedge i_mclk);
        #1 i_rstn = 1'b1;
        chk({6'h00, pin_oe}, 9'h000);
        rdx(`MGAC_OFS_CFG1);
        rdx(`MGAC_OFS_CFG2);
        wr(`MGAC_OFS_CFG1, 8'hC7);
        c1 = 8'hC7;
        rdx(`MGAC_OFS_CFG1);
        wr(`MGAC_OFS_CFG2, 8'h7B);
        c2 = 8'h7B;
        rdx(`MGAC_OFS_CFG2);
        req = '0;
        @(posedge i_mclk) #1;
        chk({6'h00, pin_oe}, {6'h00, exp_oe(c1, c2, i_alert)});
        repeat (3) @(posedge i_mclk);
        give_verdict();
    end
endmodule : tb_mgac_gpio_cfg
